// file: hdl/uhp_pkg.sv
// Purpose: shared constants and types for the hub power/config ends
// Assumes: 200 MHz system clock, four downstream ports
// Notes: all counts derive from times in their own unit
`default_nettype none
package uhp_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ = 200;
  localparam int NPORT = 4;
  localparam int XTAL_MHZ = 6;
  localparam int FAST_MHZ = 48;
  localparam int BIT_MHZ = 12;
  localparam int BIT_DIV = FAST_MHZ / BIT_MHZ;
  // overcurrent glitch filter, least time rounds up
  localparam int OC_FILT_NS = 1000;
  localparam int OC_FILT_CYC = (OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // board reset pulse and clock lead before release
  localparam int RST_MIN_US = 100;
  localparam int RST_MAX_US = 1000;
  localparam int RST_CYC = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_LEAD_US = 60;
  localparam int CLK_LEAD_CYC = (CLK_LEAD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // eeprom serial clock half period
  localparam int EE_HALF_NS = 2500;
  localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_BITS = 32;
  // ids: values are arbitrary
  localparam logic [15:0] DEF_VID = 16'h1234;
  localparam logic [15:0] DEF_PID = 16'h5678;
  localparam logic [3:0] PWR_EN_N_RST = 4'hf;
  typedef enum logic [2:0] {
    EE_OFF = 3'b000,
    EE_START = 3'b001,
    EE_LOW = 3'b010,
    EE_HIGH = 3'b011,
    EE_DONE = 3'b100
  } uhp_ee_st_t;
endpackage : uhp_pkg
`default_nettype wire

// file: hdl/uhp_if.sv
// Purpose: board-level pins between hub logic and its board
// Assumes: both ends clocked by the same system clock
// Notes: shared pins resolve here, pulldown when nobody drives
`default_nettype none
interface uhp_if;
  logic rst_n;
  logic power_source_strap;
  logic clock_select_test_strap;
  logic external_memory_strap_n;
  logic direct_fast_clock_in;
  logic crystal_in;
  logic crystal_out;
  logic suspend_status_out;
  logic [3:0] port_power_enable_n;
  logic [3:0] port_overcurrent_n;
  logic eeprom_serial_clock;
  logic eeprom_serial_clock_oe;
  logic gang_dev_do;
  logic gang_dev_oe;
  logic gang_brd_do;
  logic gang_brd_oe;
  logic eeprom_clk_lvl;
  logic eeprom_data_or_gang_pin;
  // internal pulldowns give low when undriven
  assign eeprom_clk_lvl = eeprom_serial_clock_oe & eeprom_serial_clock;
  assign eeprom_data_or_gang_pin = gang_dev_oe ? gang_dev_do :
                                   (gang_brd_oe & gang_brd_do);
  modport dev (
    input rst_n, power_source_strap, clock_select_test_strap, external_memory_strap_n,
    input direct_fast_clock_in, crystal_in, port_overcurrent_n, eeprom_data_or_gang_pin,
    output crystal_out, suspend_status_out, port_power_enable_n,
    output eeprom_serial_clock, eeprom_serial_clock_oe, gang_dev_do, gang_dev_oe
  );
  modport brd (
    output rst_n, power_source_strap, clock_select_test_strap, external_memory_strap_n,
    output direct_fast_clock_in, crystal_in, port_overcurrent_n, gang_brd_do, gang_brd_oe,
    input crystal_out, suspend_status_out, port_power_enable_n, eeprom_clk_lvl,
    input gang_dev_oe, eeprom_data_or_gang_pin
  );
endinterface : uhp_if
`default_nettype wire

// file: hdl/uhp_ocf.sv
// Purpose: glitch filter for one active-low overcurrent input
// Assumes: input already synchronous to the clock
// Notes: level must hold FILT_CYC cycles before it is believed
`default_nettype none
module uhp_ocf #(
  parameter int FILT_CYC = uhp_pkg::OC_FILT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_oc_n,
  output logic o_oc
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_TOP = CW'(FILT_CYC - 1);
  logic [CW-1:0] cnt_ff;
  logic oc_ff;
  // count while raw level disagrees, restart on any bounce
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
      oc_ff <= 1'b0;
    end else if ((~i_oc_n) == oc_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CNT_TOP) begin
      cnt_ff <= '0;
      oc_ff <= ~i_oc_n;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign o_oc = oc_ff;
endmodule : uhp_ocf
`default_nettype wire

// file: hdl/uhp_dev.sv
// Purpose: hub power, strap, clock-enable and id-load logic
// Assumes: straps stable while running; pins synchronous to i_clk_sys
// Notes: core clocks appear as one-cycle enables, not real clocks
// How it works
// RULE1: power strap high means bus powered
// RULE2: board keeps power and gang straps fixed
// RULE3: ganged: ports switch together, any trip kills all
// RULE4: per-port: each port switched and tripped alone
// RULE5: overcurrent active low, filtered against spikes
// RULE6: power switch pulls overcurrent low on fault
// RULE7: ganged board ties all overcurrent inputs together
// RULE8: power enables active low, always driven
// RULE9: test strap low: core runs from internal pll
// RULE10: test strap high: direct input, pll/osc off
// RULE11: make 48 MHz sample and 12 MHz bit enables
// RULE12: memory strap high: default id, gang pin input
// RULE13: memory strap low: read ids over serial pins
// RULE14: eeprom clock three-state with pulldown
// RULE15: eeprom data bidirectional, pulled low when idle
// RULE16: reset low initialises all logic
// RULE17: board pulses reset at power-up
// RULE18: clock runs before reset release
// RULE19: suspend output high while suspended
// RULE20: slew per port follows attached device speed
// RULE21: filtered overcurrent raises a change flag
`default_nettype none
module uhp_dev #(
  parameter int NPORT = uhp_pkg::NPORT,
  parameter int EE_HALF = uhp_pkg::EE_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  uhp_if.dev pins,
  input wire logic i_hub_suspend,
  input wire logic [NPORT-1:0] i_port_power_req,
  input wire logic [NPORT-1:0] i_port_low_speed,
  input wire logic [NPORT-1:0] i_oc_change_clr,
  input wire logic i_hub_oc_clr,
  output logic o_fast_en,
  output logic o_bit_en,
  output logic o_pll_pwr_dn,
  output logic o_osc_pwr_dn,
  output logic o_bus_powered,
  output logic o_ganged,
  output logic [NPORT-1:0] o_port_slew_ls,
  output logic [NPORT-1:0] o_port_powered,
  output logic [NPORT-1:0] o_port_oc,
  output logic [NPORT-1:0] o_oc_change,
  output logic o_hub_oc_change,
  output logic [15:0] o_vid,
  output logic [15:0] o_pid,
  output logic o_id_valid
);
  localparam int EW = $clog2(EE_HALF + 1);
  localparam logic [EW-1:0] EE_TOP = EW'(EE_HALF - 1);
  localparam logic [7:0] ACC_INC = 8'(uhp_pkg::FAST_MHZ);
  localparam logic [7:0] ACC_MOD = 8'(uhp_pkg::CLK_MHZ);
  localparam logic [1:0] BIT_TOP = 2'(uhp_pkg::BIT_DIV - 1);
  localparam logic [5:0] ID_TOP = 6'(uhp_pkg::ID_BITS - 1);

  logic strap_ok_ff, bus_pwr_ff, test_clk_ff, ext_mem_n_ff, gang_ff;
  logic [7:0] acc_ff;
  logic fast_in_ff, fast_en_ff, bit_en_ff, xo_ff;
  logic [1:0] bit_cnt_ff;
  logic [NPORT-1:0] oc_f, oc_prev_ff, off_ff, pwr_ff, chg_ff, slew_ff;
  logic oc_any_prev_ff, hub_chg_ff, susp_ff;
  logic [NPORT-1:0] eff_req, trip;
  logic oc_any, req_any;
  logic [7:0] nxt_acc;
  logic nxt_fast_en;
  uhp_pkg::uhp_ee_st_t ee_st_ff;
  logic [EW-1:0] ee_cnt_ff;
  logic [5:0] ee_bit_ff;
  logic [31:0] ee_sh_ff;
  logic ee_clk_ff, ee_clk_oe_ff, ee_do_oe_ff, id_ok_ff;

  // straps caught once, first cycle after reset release
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin  // RULE16
      strap_ok_ff <= 1'b0;
      bus_pwr_ff <= 1'b0;
      test_clk_ff <= 1'b0;
      ext_mem_n_ff <= 1'b1;
      gang_ff <= 1'b0;
    end else if (!strap_ok_ff) begin  // RULE2
      strap_ok_ff <= 1'b1;
      bus_pwr_ff <= pins.power_source_strap;  // RULE1
      test_clk_ff <= pins.clock_select_test_strap;
      ext_mem_n_ff <= pins.external_memory_strap_n;
      // pin is eeprom data when memory is fitted, so per-port then
      gang_ff <= pins.external_memory_strap_n & pins.eeprom_data_or_gang_pin;  // RULE12
    end
  end

  // pll stand-in: fractional 48/200 accumulator; direct mode uses input edges
  always_comb begin
    nxt_acc = acc_ff + ACC_INC;
    nxt_fast_en = 1'b0;
    if (test_clk_ff) begin  // RULE10
      nxt_acc = '0;
      nxt_fast_en = pins.direct_fast_clock_in & ~fast_in_ff;
    end else if (nxt_acc >= ACC_MOD) begin  // RULE9
      nxt_acc = nxt_acc - ACC_MOD;
      nxt_fast_en = strap_ok_ff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_ff <= '0;
      fast_in_ff <= 1'b0;
      fast_en_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      fast_in_ff <= pins.direct_fast_clock_in;
      fast_en_ff <= nxt_fast_en;  // RULE11
    end
  end

  // bit enable every fourth sample enable
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_ff <= '0;
      bit_en_ff <= 1'b0;
    end else begin
      bit_en_ff <= fast_en_ff && (bit_cnt_ff == BIT_TOP);  // RULE11
      if (fast_en_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
    end
  end

  // oscillator inverter, silent when powered down
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      xo_ff <= 1'b0;
    end else begin
      xo_ff <= ~test_clk_ff & ~pins.crystal_in;  // RULE10
    end
  end

  // one filter per port
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_ocf
      uhp_ocf u_ocf (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_oc_n(pins.port_overcurrent_n[g]),  // RULE5
        .o_oc(oc_f[g])
      );
    end
  endgenerate

  // ganged mode folds requests and trips to hub level
  assign oc_any = |oc_f;
  assign req_any = |i_port_power_req;
  assign eff_req = gang_ff ? {NPORT{req_any}} : i_port_power_req;  // RULE3 RULE4
  assign trip = gang_ff ? {NPORT{oc_any}} : oc_f;  // RULE3 RULE4

  // trip latches power off until the port request drops
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      off_ff <= '0;
      pwr_ff <= '0;
    end else begin
      off_ff <= trip | (off_ff & eff_req);  // RULE3 RULE4
      pwr_ff <= eff_req & ~trip & ~off_ff & {NPORT{strap_ok_ff}};
    end
  end

  // change flags: a new trip beats a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oc_prev_ff <= '0;
      oc_any_prev_ff <= 1'b0;
      chg_ff <= '0;
      hub_chg_ff <= 1'b0;
    end else begin
      oc_prev_ff <= oc_f;
      oc_any_prev_ff <= oc_any;
      chg_ff <= ({NPORT{~gang_ff}} & oc_f & ~oc_prev_ff) | (chg_ff & ~i_oc_change_clr);  // RULE21
      hub_chg_ff <= (gang_ff & oc_any & ~oc_any_prev_ff) | (hub_chg_ff & ~i_hub_oc_clr);  // RULE21
    end
  end

  // suspend status and per-port slew
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      susp_ff <= 1'b0;
      slew_ff <= '0;
    end else begin
      susp_ff <= i_hub_suspend;  // RULE19
      slew_ff <= i_port_low_speed;  // RULE20
    end
  end

  // id loader: start marker, then 32 bits sampled at clock-high end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ee_st_ff <= uhp_pkg::EE_OFF;
      ee_cnt_ff <= '0;
      ee_bit_ff <= '0;
      ee_sh_ff <= '0;
      ee_clk_ff <= 1'b0;
      ee_clk_oe_ff <= 1'b0;
      ee_do_oe_ff <= 1'b0;
      id_ok_ff <= 1'b0;
    end else begin
      ee_cnt_ff <= (ee_cnt_ff == EE_TOP) ? '0 : ee_cnt_ff + 1'b1;
      case (ee_st_ff)
        uhp_pkg::EE_OFF: begin
          ee_cnt_ff <= '0;
          if (strap_ok_ff && !ext_mem_n_ff && !id_ok_ff) begin  // RULE13
            ee_st_ff <= uhp_pkg::EE_START;
            ee_clk_ff <= 1'b1;
            ee_clk_oe_ff <= 1'b1;  // RULE14
            ee_do_oe_ff <= 1'b1;  // RULE15
          end else if (strap_ok_ff && ext_mem_n_ff) begin
            id_ok_ff <= 1'b1;  // RULE12
          end
        end
        uhp_pkg::EE_START: begin
          if (ee_cnt_ff == EE_TOP) begin
            ee_st_ff <= uhp_pkg::EE_LOW;
            ee_clk_ff <= 1'b0;
            ee_do_oe_ff <= 1'b0;  // RULE15
          end
        end
        uhp_pkg::EE_LOW: begin
          if (ee_cnt_ff == EE_TOP) begin
            ee_st_ff <= uhp_pkg::EE_HIGH;
            ee_clk_ff <= 1'b1;
          end
        end
        uhp_pkg::EE_HIGH: begin
          if (ee_cnt_ff == EE_TOP) begin
            ee_sh_ff <= {ee_sh_ff[30:0], pins.eeprom_data_or_gang_pin};  // RULE13
            ee_clk_ff <= 1'b0;
            ee_bit_ff <= ee_bit_ff + 1'b1;
            ee_st_ff <= (ee_bit_ff == ID_TOP) ? uhp_pkg::EE_DONE : uhp_pkg::EE_LOW;
          end
        end
        uhp_pkg::EE_DONE: begin
          ee_clk_oe_ff <= 1'b0;  // RULE14
          id_ok_ff <= 1'b1;
          ee_st_ff <= uhp_pkg::EE_OFF;
        end
        default: begin
          ee_st_ff <= uhp_pkg::EE_OFF;
        end
      endcase
    end
  end

  // pins: power enables push-pull, low means on
  assign pins.port_power_enable_n = ~pwr_ff;  // RULE8
  assign pins.crystal_out = xo_ff;
  assign pins.suspend_status_out = susp_ff;
  assign pins.eeprom_serial_clock = ee_clk_ff;
  assign pins.eeprom_serial_clock_oe = ee_clk_oe_ff;
  assign pins.gang_dev_do = 1'b0;
  assign pins.gang_dev_oe = ee_do_oe_ff;

  assign o_fast_en = fast_en_ff;
  assign o_bit_en = bit_en_ff;
  assign o_pll_pwr_dn = test_clk_ff;
  assign o_osc_pwr_dn = test_clk_ff;
  assign o_bus_powered = bus_pwr_ff;
  assign o_ganged = gang_ff;
  assign o_port_slew_ls = slew_ff;
  assign o_port_powered = pwr_ff;
  assign o_port_oc = oc_prev_ff;
  assign o_oc_change = chg_ff;
  assign o_hub_oc_change = hub_chg_ff;
  // default ids when no memory is fitted
  assign o_vid = ext_mem_n_ff ? uhp_pkg::DEF_VID : ee_sh_ff[31:16];
  assign o_pid = ext_mem_n_ff ? uhp_pkg::DEF_PID : ee_sh_ff[15:0];
  assign o_id_valid = id_ok_ff;
endmodule : uhp_dev
`default_nettype wire

// file: hdl/uhp_brd.sv
// Purpose: board side: straps, reset pulse, clocks, switches, id memory
// Assumes: same system clock as the hub logic
// Notes: straps freeze when the hub reset is released
`default_nettype none
module uhp_brd #(
  parameter int RST_CYC = uhp_pkg::RST_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  uhp_if.brd pins,
  input wire logic i_bus_powered,
  input wire logic i_use_direct_clk,
  input wire logic i_ext_mem_n,
  input wire logic i_ganged,
  input wire logic [3:0] i_port_fault,
  input wire logic [31:0] i_ee_id,
  output logic o_reset_done
);
  localparam int RW = $clog2(RST_CYC + 1);
  localparam logic [7:0] ACC_MOD = 8'(uhp_pkg::CLK_MHZ);
  localparam logic [7:0] INC [2] = '{8'(2 * uhp_pkg::XTAL_MHZ), 8'(2 * uhp_pkg::FAST_MHZ)};
  logic [RW-1:0] rcnt_ff;
  logic rst_n_ff, bp_ff, tc_ff, em_ff, gg_ff;
  logic [1:0] ck_ff;
  logic [7:0] acc_ff [2];
  logic [3:0] oc_n_ff;
  logic [5:0] idx_ff;
  logic clk_prev_ff, dat_ff, dat_oe_ff;
  logic [3:0] fault_on;

  // reset pulse; straps follow inputs only while it is held
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rcnt_ff <= '0;
      rst_n_ff <= 1'b0;
      bp_ff <= 1'b0;
      tc_ff <= 1'b0;
      em_ff <= 1'b1;
      gg_ff <= 1'b0;
    end else if (!rst_n_ff) begin  // RULE2 RULE17
      rcnt_ff <= rcnt_ff + 1'b1;
      rst_n_ff <= (rcnt_ff == RW'(RST_CYC - 1));
      bp_ff <= i_bus_powered;
      tc_ff <= i_use_direct_clk;
      em_ff <= i_ext_mem_n;
      gg_ff <= i_ganged;
    end
  end

  // crystal and direct clocks run from board reset on, ahead of release
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ck
      always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
          acc_ff[g] <= '0;
          ck_ff[g] <= 1'b0;
        end else if (9'(acc_ff[g]) + 9'(INC[g]) >= 9'(ACC_MOD)) begin  // RULE18
          acc_ff[g] <= acc_ff[g] + INC[g] - ACC_MOD;
          ck_ff[g] <= ~ck_ff[g];
        end else begin
          acc_ff[g] <= acc_ff[g] + INC[g];
        end
      end
    end
  endgenerate

  // power switch reports fault on powered ports; ganged inputs tied
  assign fault_on = i_port_fault & ~pins.port_power_enable_n;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oc_n_ff <= 4'hf;
    end else begin
      oc_n_ff <= gg_ff ? {4{~|fault_on}} : ~fault_on;  // RULE6 RULE7
    end
  end

  // id memory: restart on start marker, next bit on clock fall
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idx_ff <= '0;
      clk_prev_ff <= 1'b0;
      dat_ff <= 1'b0;
      dat_oe_ff <= 1'b0;
    end else begin
      clk_prev_ff <= pins.eeprom_clk_lvl;
      if (pins.gang_dev_oe) begin
        idx_ff <= '0;
        dat_oe_ff <= 1'b0;
      end else if (clk_prev_ff && !pins.eeprom_clk_lvl && idx_ff < 6'd32) begin
        dat_ff <= i_ee_id[5'(31 - idx_ff)];
        dat_oe_ff <= 1'b1;
        idx_ff <= idx_ff + 1'b1;
      end else if (idx_ff == 6'd32 && clk_prev_ff && !pins.eeprom_clk_lvl) begin
        dat_oe_ff <= 1'b0;
      end
    end
  end

  assign pins.rst_n = rst_n_ff;
  assign pins.power_source_strap = bp_ff;
  assign pins.clock_select_test_strap = tc_ff;
  assign pins.external_memory_strap_n = em_ff;
  assign pins.crystal_in = ck_ff[0];
  assign pins.direct_fast_clock_in = ck_ff[1] & tc_ff;
  assign pins.port_overcurrent_n = oc_n_ff;
  assign pins.gang_brd_oe = em_ff | dat_oe_ff;
  assign pins.gang_brd_do = em_ff ? gg_ff : dat_ff;
  assign o_reset_done = rst_n_ff;
endmodule : uhp_brd
`default_nettype wire

// file: tb/uhp_checker.sv
// Purpose: pin-level checks between hub logic and board
// Assumes: one clock; eeprom half period of 4 cycles
// Notes: the overcurrent counter runs only while the hub is out of reset
`default_nettype none
module uhp_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic rst_n,
  input wire logic clock_select_test_strap,
  input wire logic external_memory_strap_n,
  input wire logic crystal_in,
  input wire logic crystal_out,
  input wire logic [3:0] port_power_enable_n,
  input wire logic [3:0] port_overcurrent_n,
  input wire logic eeprom_serial_clock_oe,
  input wire logic gang_dev_oe,
  input wire logic eeprom_clk_lvl,
  input wire logic eeprom_data_or_gang_pin
);
  logic [3:0][8:0] oc_low_ff;
  // consecutive low samples per overcurrent pin, saturating
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_low_ff <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (port_overcurrent_n[i]) oc_low_ff[i] <= 9'h000;
        else if (oc_low_ff[i] != 9'h1ff) oc_low_ff[i] <= oc_low_ff[i] + 9'h001;
      end
    end
  end
  // the board reports a fault only while powered, so a low held past the filter time means a missed trip
  for (genvar g = 0; g < 4; g++) begin : g_oc
    AST_OC_TRIP: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      oc_low_ff[g] <= 9'h0ce) else $error("overcurrent held without power off");
    AST_OC_FILTERED: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      $rose(port_power_enable_n[g]) && !port_overcurrent_n[g] |-> oc_low_ff[g] >= 9'h0c7)
      else $error("power off before overcurrent filter time");
  end
  AST_PWR_OFF_RST: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> $past(port_power_enable_n) == 4'hf && !$past(eeprom_serial_clock_oe))
    else $error("outputs active during reset");
  AST_GANG_TOGETHER: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    external_memory_strap_n && eeprom_data_or_gang_pin |->
    port_power_enable_n == 4'h0 || port_power_enable_n == 4'hf)
    else $error("ganged ports switched apart");
  AST_NO_MEM_IDLE: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    external_memory_strap_n |-> !eeprom_serial_clock_oe && !gang_dev_oe)
    else $error("eeprom pins driven without memory");
  // written for a half period of 4 cycles
  AST_EE_HIGH: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(eeprom_clk_lvl) |-> eeprom_clk_lvl [*4] ##1 !eeprom_clk_lvl)
    else $error("eeprom clock high phase wrong");
  AST_OSC_OFF: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $past(rst_n, 3) && clock_select_test_strap |-> !crystal_out)
    else $error("oscillator running in direct mode");
  AST_OSC_RUN: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $past(rst_n, 3) && !clock_select_test_strap |-> crystal_out == !$past(crystal_in))
    else $error("oscillator not following crystal");
  AST_RST_LEN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(rst_n) |-> !$past(rst_n, 8) && !$past(rst_n, 15))
    else $error("hub reset pulse too short");
  AST_C_EE_DONE: cover property (@(posedge i_clk_sys) $fell(eeprom_serial_clock_oe));
  AST_C_TRIP: cover property (@(posedge i_clk_sys) $rose(port_power_enable_n[2]));
  AST_C_GANG_ON: cover property (@(posedge i_clk_sys)
    external_memory_strap_n && eeprom_data_or_gang_pin && port_power_enable_n == 4'h0);
endmodule : uhp_checker
`default_nettype wire

// file: tb/usb_hub_port_power_config_tb.sv
// Purpose: drives hub logic and board model back to back
// Assumes: board reset length 16, eeprom half period 4
// Notes: every scenario but the suspend/slew one restarts both ends with fresh straps
`default_nettype none
module usb_hub_port_power_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic bus_pwr = 1'b0, direct = 1'b0, ext_n = 1'b1, gang = 1'b0;
  logic [3:0] fault = 4'h0, req = 4'h0, low_spd = 4'h0, oc_clr = 4'h0;
  logic [31:0] ee_id = 32'h9a3c_5e71;
  logic suspend = 1'b0, hub_clr = 1'b0;
  logic fast_en, bit_en, pll_dn, osc_dn, bus_powered, ganged, hub_oc_chg, id_valid, rst_done;
  logic [3:0] slew_ls, powered, oc_chg, port_oc;
  logic [15:0] vid, pid;
  int err_count = 0;
  int checked = 0;
  uhp_if uhp_if_inst();
  uhp_dev #(.EE_HALF(4)) uhp_dev_inst (.i_clk_sys(clk_sys), .i_rst_b(uhp_if_inst.rst_n),
    .pins(uhp_if_inst), .i_hub_suspend(suspend), .i_port_power_req(req),
    .i_port_low_speed(low_spd), .i_oc_change_clr(oc_clr), .i_hub_oc_clr(hub_clr),
    .o_fast_en(fast_en), .o_bit_en(bit_en), .o_pll_pwr_dn(pll_dn), .o_osc_pwr_dn(osc_dn),
    .o_bus_powered(bus_powered), .o_ganged(ganged), .o_port_slew_ls(slew_ls),
    .o_port_powered(powered), .o_port_oc(port_oc), .o_oc_change(oc_chg),
    .o_hub_oc_change(hub_oc_chg), .o_vid(vid), .o_pid(pid), .o_id_valid(id_valid));
  uhp_brd #(.RST_CYC(16)) uhp_brd_inst (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
    .pins(uhp_if_inst), .i_bus_powered(bus_pwr), .i_use_direct_clk(direct),
    .i_ext_mem_n(ext_n), .i_ganged(gang), .i_port_fault(fault), .i_ee_id(ee_id),
    .o_reset_done(rst_done));
  uhp_checker uhp_checker_inst (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
    .rst_n(uhp_if_inst.rst_n), .clock_select_test_strap(uhp_if_inst.clock_select_test_strap),
    .external_memory_strap_n(uhp_if_inst.external_memory_strap_n),
    .crystal_in(uhp_if_inst.crystal_in), .crystal_out(uhp_if_inst.crystal_out),
    .port_power_enable_n(uhp_if_inst.port_power_enable_n),
    .port_overcurrent_n(uhp_if_inst.port_overcurrent_n),
    .eeprom_serial_clock_oe(uhp_if_inst.eeprom_serial_clock_oe),
    .gang_dev_oe(uhp_if_inst.gang_dev_oe), .eeprom_clk_lvl(uhp_if_inst.eeprom_clk_lvl),
    .eeprom_data_or_gang_pin(uhp_if_inst.eeprom_data_or_gang_pin));
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  // inputs move 1 ns after the edge so no race with sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // straps only move while the board holds everything in reset
  task automatic restart(input logic bp, input logic dir, input logic en, input logic gm);
    req = 4'h0;
    rst_b = 1'b0;
    {bus_pwr, direct, ext_n, gang} = {bp, dir, en, gm};
    step(8);
    chk("power_enable_n in reset", 32'h0000000f, 32'(uhp_if_inst.port_power_enable_n));
    rst_b = 1'b1;
    for (int k = 0; k < 100 && rst_done !== 1'b1; k++) step(1);
    step(3);
  endtask : restart
  task automatic cfg_case(input logic bp, input logic dir, input logic gm);
    int fast;
    int bits;
    fast = 0;
    bits = 0;
    restart(bp, dir, 1'b1, gm);
    chk("bus_powered", 32'(bp), 32'(bus_powered));
    chk("pll_pwr_dn", 32'(dir), 32'(pll_dn));
    chk("osc_pwr_dn", 32'(dir), 32'(osc_dn));
    chk("ganged", 32'(gm), 32'(ganged));
    chk("id_valid", 32'h1, 32'(id_valid));
    chk("pid default", 32'(uhp_pkg::DEF_PID), 32'(pid));
    chk("vid default", 32'(uhp_pkg::DEF_VID), 32'(vid));
    repeat (1000) begin
      step(1);
      fast += int'(fast_en);
      bits += int'(bit_en);
    end
    chk("fast_en rate", 32'h1, 32'(dir ? fast > 100 : fast >= 239 && fast <= 241));
    chk("bit_en ratio", 32'h1, 32'(bits * 4 <= fast + 4 && bits * 4 + 4 >= fast));
  endtask : cfg_case
  // spike ignored, real trip kills one port, latched until request drops
  task automatic per_port_case();
    restart(1'b0, 1'b0, 1'b1, 1'b0);
    req = 4'h5;
    step(2);
    chk("enable_n per port", 32'h0000000a, 32'(uhp_if_inst.port_power_enable_n));
    chk("port_powered", 32'h5, 32'(powered));
    fault = 4'h1;
    step(50);
    fault = 4'h0;
    step(5);
    chk("enable_n after spike", 32'h0000000a, 32'(uhp_if_inst.port_power_enable_n));
    chk("oc_change after spike", 32'h0, 32'(oc_chg));
    fault = 4'h4;
    step(210);
    chk("enable_n after trip", 32'h0000000e, 32'(uhp_if_inst.port_power_enable_n));
    chk("oc_change after trip", 32'h4, 32'(oc_chg));
    chk("port_oc after trip", 32'h4, 32'(port_oc));
    fault = 4'h0;
    oc_clr = 4'h4;
    step(1);
    oc_clr = 4'h0;
    step(2);
    chk("oc_change cleared", 32'h0, 32'(oc_chg));
    chk("tripped port stays off", 32'h0000000e, 32'(uhp_if_inst.port_power_enable_n));
    // filtered trip lingers one filter time after the switch lets go
    step(200);
    chk("port_oc released", 32'h0, 32'(port_oc));
    req = 4'h1;
    step(1);
    req = 4'h5;
    step(2);
    chk("port back on", 32'h0000000a, 32'(uhp_if_inst.port_power_enable_n));
  endtask : per_port_case
  task automatic ganged_case();
    restart(1'b1, 1'b0, 1'b1, 1'b1);
    req = 4'h1;
    step(2);
    chk("ganged all on", 32'h0, 32'(uhp_if_inst.port_power_enable_n));
    fault = 4'h8;
    step(210);
    chk("ganged all off", 32'h0000000f, 32'(uhp_if_inst.port_power_enable_n));
    chk("hub_oc_change", 32'h1, 32'(hub_oc_chg));
    fault = 4'h0;
    hub_clr = 1'b1;
    step(1);
    hub_clr = 1'b0;
    step(2);
    chk("hub_oc_change cleared", 32'h0, 32'(hub_oc_chg));
  endtask : ganged_case
  // memory fitted: ids come over the serial pins, gang input unused
  task automatic eeprom_case();
    restart(1'b0, 1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 3000 && id_valid !== 1'b1; k++) step(1);
    step(2);
    chk("vid from memory", 32'h00009a3c, 32'(vid));
    chk("pid from memory", 32'h00005e71, 32'(pid));
    chk("ganged with memory", 32'h0, 32'(ganged));
    chk("eeprom clock released", 32'h0, 32'(uhp_if_inst.eeprom_serial_clock_oe));
    chk("eeprom data released", 32'h0, 32'(uhp_if_inst.eeprom_data_or_gang_pin));
    chk("eeprom data oe", 32'h0, 32'(uhp_if_inst.gang_dev_oe));
  endtask : eeprom_case
  task automatic susp_slew_case();
    suspend = 1'b1;
    low_spd = 4'h9;
    step(2);
    chk("suspend high", 32'h1, 32'(uhp_if_inst.suspend_status_out));
    chk("slew low speed", 32'h9, 32'(slew_ls));
    suspend = 1'b0;
    low_spd = 4'h6;
    step(2);
    chk("suspend low", 32'h0, 32'(uhp_if_inst.suspend_status_out));
    chk("slew swapped", 32'h6, 32'(slew_ls));
  endtask : susp_slew_case
  // main sequence
  initial begin
    cfg_case(1'b1, 1'b0, 1'b0);
    cfg_case(1'b0, 1'b1, 1'b1);
    per_port_case();
    ganged_case();
    eeprom_case();
    susp_slew_case();
    complete_run();
  end
  // over six times the expected run length
  initial begin
    #100us;
    err_count++;
    complete_run();
  end
endmodule : usb_hub_port_power_config_tb
`default_nettype wire
